// File: pkg/aer_log_pkg.sv
// Constants and carrier types for the correctable error log register bank
package aer_log_pkg;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [11:0] OFS_CORR_STATUS = 12'h110;
	localparam logic [11:0] OFS_CORR_MASK   = 12'h114;
	localparam logic [11:0] OFS_CAP_CTRL    = 12'h118;
	localparam logic [11:0] OFS_HDR_LOG0    = 12'h11C;
	localparam logic [11:0] OFS_HDR_LOG1    = 12'h120;
	localparam logic [11:0] OFS_HDR_LOG2    = 12'h124;
	localparam logic [11:0] OFS_HDR_LOG3    = 12'h128;

	// ----------------------------------------------------------------
	// Correctable status and mask bit positions
	// ----------------------------------------------------------------
	localparam int BIT_RX_ERR       = 0;
	localparam int BIT_BAD_TLP      = 6;
	localparam int BIT_BAD_DLLP     = 7;
	localparam int BIT_REPLAY_ROLL  = 8;
	localparam int BIT_REPLAY_TMO   = 12;
	localparam int BIT_ADVISORY_NF  = 13;

	// Implemented bits of status and mask; reserved bits read zero
	localparam logic [31:0] CORR_IMPL_MASK   = 32'h0000_31C1;
	localparam logic [31:0] CORR_STATUS_RST  = 32'h0000_0000;
	localparam logic [31:0] CORR_MASK_RST    = 32'h0000_2000;

	// ----------------------------------------------------------------
	// Capabilities and control fields
	// ----------------------------------------------------------------
	localparam int BIT_FEP_LSB      = 0;
	localparam int BIT_ECRC_GEN_CAP = 5;
	localparam int BIT_ECRC_GEN_EN  = 6;
	localparam int BIT_ECRC_CHK_CAP = 7;
	localparam int BIT_ECRC_CHK_EN  = 8;
	localparam logic [4:0] FEP_RST  = 5'h00;
	localparam logic       ECRC_EN_RST = 1'b0;
	localparam logic       ECRC_CAP_VAL = 1'b1;

	localparam int HDR_DWORDS = 4;
	localparam int HDR_BYTES  = 16;

	// ----------------------------------------------------------------
	// Carrier types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic advisory_nf;
		logic replay_tmo;
		logic replay_roll;
		logic bad_dllp;
		logic bad_tlp;
		logic rx_err;
	} corr_evt_t;

	// Byte 0 is the first header byte on the wire
	typedef logic [HDR_BYTES-1:0][7:0] hdr_bytes_t;

	typedef enum logic [0:0] {
		BUS_IDLE,
		BUS_ACK
	} bus_state_t;

	typedef struct packed {
		bus_state_t   bus;
		logic         waitreq;
		logic [31:0]  rdata;
		logic [31:0]  status;
		logic [31:0]  mask;
		logic [4:0]   fep;
		logic         ecrc_gen_en;
		logic         ecrc_chk_en;
		logic [127:0] hdr_log;
		logic         msg;
		corr_evt_t    msg_kind;
	} aer_state_t;

endpackage : aer_log_pkg

// File: verilog/aer_correctable_error_log.sv
// Correctable error status, mask, control and header log for one port
//
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module aer_correctable_error_log
(
	// Clock and fundamental reset
	input  wire logic                    core_clk_i,
	input  wire logic                    rstn_i,
	// Hot or link reset from the port, same clock domain
	input  wire logic                    hot_reset_i,
	// Avalon-MM slave
	input  wire logic [11:0]             avs_address_i,
	input  wire logic                    avs_read_i,
	input  wire logic                    avs_write_i,
	input  wire logic [31:0]             avs_writedata_i,
	input  wire logic [3:0]              avs_byteenable_i,
	output logic      [31:0]             avs_readdata_o,
	output logic                         avs_waitrequest_o,
	// Error events from the link logic, one-cycle pulses
	input  wire aer_log_pkg::corr_evt_t  evt_i,
	input  wire logic                    evt_hdr_valid_i,
	input  wire aer_log_pkg::hdr_bytes_t evt_hdr_i,
	// First error pointer update from uncorrectable logic
	input  wire logic                    fep_load_i,
	input  wire logic [4:0]              fep_value_i,
	// Outputs to the port
	output logic                         err_msg_o,
	output aer_log_pkg::corr_evt_t       err_msg_kind_o,
	output logic                         ecrc_gen_en_o,
	output logic                         ecrc_chk_en_o
);

	aer_log_pkg::aer_state_t st;
	aer_log_pkg::aer_state_t next_st;

	// ----------------------------------------------------------------
	// Event vector at status bit positions
	// ----------------------------------------------------------------
	logic [31:0] evt_vec;
	logic [31:0] unmasked;
	logic [127:0] hdr_packed;

	always_comb
	begin
		evt_vec = 32'h0000_0000;
		evt_vec[aer_log_pkg::BIT_RX_ERR]      = evt_i.rx_err;
		evt_vec[aer_log_pkg::BIT_BAD_TLP]     = evt_i.bad_tlp;
		evt_vec[aer_log_pkg::BIT_BAD_DLLP]    = evt_i.bad_dllp;
		evt_vec[aer_log_pkg::BIT_REPLAY_ROLL] = evt_i.replay_roll;
		evt_vec[aer_log_pkg::BIT_REPLAY_TMO]  = evt_i.replay_tmo;
		evt_vec[aer_log_pkg::BIT_ADVISORY_NF] = evt_i.advisory_nf;
		// Mask gates only logging and messaging
		unmasked = evt_vec & ~st.mask & aer_log_pkg::CORR_IMPL_MASK;
	end

	// Header bytes to dwords, first byte in the top lane of each dword
	always_comb
	begin
		for (int d = 0; d < aer_log_pkg::HDR_DWORDS; d++)
		begin
			hdr_packed[d*32 +: 32] = {evt_hdr_i[4*d], evt_hdr_i[4*d+1],
			                          evt_hdr_i[4*d+2], evt_hdr_i[4*d+3]};
		end
	end

	// ----------------------------------------------------------------
	// Register read mux
	// ----------------------------------------------------------------
	function automatic logic [31:0] read_reg(input aer_log_pkg::aer_state_t s,
	                                         input logic [11:0] adr);
		logic [31:0] v;
		v = 32'h0000_0000;
		unique case (adr)
			aer_log_pkg::OFS_CORR_STATUS: v = s.status & aer_log_pkg::CORR_IMPL_MASK;
			aer_log_pkg::OFS_CORR_MASK:   v = s.mask & aer_log_pkg::CORR_IMPL_MASK;
			aer_log_pkg::OFS_CAP_CTRL:
			begin
				v[aer_log_pkg::BIT_FEP_LSB +: 5]      = s.fep;
				v[aer_log_pkg::BIT_ECRC_GEN_CAP]      = aer_log_pkg::ECRC_CAP_VAL;
				v[aer_log_pkg::BIT_ECRC_GEN_EN]       = s.ecrc_gen_en;
				v[aer_log_pkg::BIT_ECRC_CHK_CAP]      = aer_log_pkg::ECRC_CAP_VAL;
				v[aer_log_pkg::BIT_ECRC_CHK_EN]       = s.ecrc_chk_en;
			end
			aer_log_pkg::OFS_HDR_LOG0:    v = s.hdr_log[31:0];
			aer_log_pkg::OFS_HDR_LOG1:    v = s.hdr_log[63:32];
			aer_log_pkg::OFS_HDR_LOG2:    v = s.hdr_log[95:64];
			aer_log_pkg::OFS_HDR_LOG3:    v = s.hdr_log[127:96];
			default:                      v = 32'h0000_0000;
		endcase
		return v;
	endfunction : read_reg

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	logic [31:0] be_bits;
	logic        wr_now;
	logic [31:0] w1c;

	always_comb
	begin
		next_st = st;
		be_bits = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
		           {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
		// Write lands at the edge where waitrequest is seen low
		wr_now  = (st.bus == aer_log_pkg::BUS_ACK) && avs_write_i;
		w1c     = 32'h0000_0000;

		unique case (st.bus)
			aer_log_pkg::BUS_IDLE:
			begin
				next_st.waitreq = 1'b1;
				if (avs_read_i || avs_write_i)
				begin
					next_st.bus     = aer_log_pkg::BUS_ACK;
					next_st.waitreq = 1'b0;
					next_st.rdata   = avs_read_i ? read_reg(st, avs_address_i) : 32'h0000_0000;
				end
			end
			aer_log_pkg::BUS_ACK:
			begin
				next_st.bus     = aer_log_pkg::BUS_IDLE;
				next_st.waitreq = 1'b1;
			end
		endcase

		if (wr_now)
		begin
			unique case (avs_address_i)
				aer_log_pkg::OFS_CORR_STATUS:
					w1c = avs_writedata_i & be_bits & aer_log_pkg::CORR_IMPL_MASK;
				aer_log_pkg::OFS_CORR_MASK:
					next_st.mask = ((st.mask & ~be_bits) | (avs_writedata_i & be_bits))
					               & aer_log_pkg::CORR_IMPL_MASK;
				aer_log_pkg::OFS_CAP_CTRL:
				begin
					if (avs_byteenable_i[0])
						next_st.ecrc_gen_en = avs_writedata_i[aer_log_pkg::BIT_ECRC_GEN_EN];
					if (avs_byteenable_i[1])
						next_st.ecrc_chk_en = avs_writedata_i[aer_log_pkg::BIT_ECRC_CHK_EN];
				end
				default:
					w1c = 32'h0000_0000;
			endcase
		end

		// A new event beats a clear in the same cycle
		next_st.status = ((st.status & ~w1c) | evt_vec)
		                 & aer_log_pkg::CORR_IMPL_MASK;

		// Unmasked events raise a message; header logs when one is carried
		next_st.msg      = |unmasked;
		next_st.msg_kind.rx_err      = unmasked[aer_log_pkg::BIT_RX_ERR];
		next_st.msg_kind.bad_tlp     = unmasked[aer_log_pkg::BIT_BAD_TLP];
		next_st.msg_kind.bad_dllp    = unmasked[aer_log_pkg::BIT_BAD_DLLP];
		next_st.msg_kind.replay_roll = unmasked[aer_log_pkg::BIT_REPLAY_ROLL];
		next_st.msg_kind.replay_tmo  = unmasked[aer_log_pkg::BIT_REPLAY_TMO];
		next_st.msg_kind.advisory_nf = unmasked[aer_log_pkg::BIT_ADVISORY_NF];
		if ((|unmasked) && evt_hdr_valid_i)
			next_st.hdr_log = hdr_packed;

		if (fep_load_i)
			next_st.fep = fep_value_i;

		// Hot or link reset drops only the non-sticky message pulse
		if (hot_reset_i)
		begin
			next_st.msg      = 1'b0;
			next_st.msg_kind = '0;
		end
	end

	// ----------------------------------------------------------------
	// State register; only the fundamental reset clears sticky state
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			st             <= '0;
			st.bus         <= aer_log_pkg::BUS_IDLE;
			st.waitreq     <= 1'b1;
			st.status      <= aer_log_pkg::CORR_STATUS_RST;
			st.mask        <= aer_log_pkg::CORR_MASK_RST;
			st.fep         <= aer_log_pkg::FEP_RST;
			st.ecrc_gen_en <= aer_log_pkg::ECRC_EN_RST;
			st.ecrc_chk_en <= aer_log_pkg::ECRC_EN_RST;
		end
		else
		begin
			st <= next_st;
		end
	end

	// ----------------------------------------------------------------
	// Outputs, all straight from the state register
	// ----------------------------------------------------------------
	assign avs_readdata_o    = st.rdata;
	assign avs_waitrequest_o = st.waitreq;
	assign err_msg_o         = st.msg;
	assign err_msg_kind_o    = st.msg_kind;
	assign ecrc_gen_en_o     = st.ecrc_gen_en;
	assign ecrc_chk_en_o     = st.ecrc_chk_en;

endmodule : aer_correctable_error_log

`default_nettype wire

// File: sim/link_err_src.sv
// Link-side model raising correctable error events with headers
`timescale 1ns/10ps
`default_nettype none
module link_err_src
(
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rstn_i,
	// Bench command
	input wire logic go_i,
	input wire aer_log_pkg::corr_evt_t kind_i,
	// Toward the port logic
	output aer_log_pkg::corr_evt_t evt_o,
	output logic hdr_valid_o,
	output aer_log_pkg::hdr_bytes_t hdr_o
);
	logic [7:0] cnt;
	// Header lines churn every cycle so a stale capture shows
	always_comb
		for (int k = 0; k < 16; k++)
			hdr_o[k] = cnt + 8'(37 * k);
	always_ff @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			cnt <= 8'h5A;
			evt_o <= '0;
			hdr_valid_o <= 1'b0;
		end
		else
		begin
			cnt <= cnt + 8'h0D;
			evt_o <= go_i ? kind_i : '0;
			hdr_valid_o <= go_i;
		end
	end
endmodule : link_err_src
`default_nettype wire

// File: sim/aer_log_sva.sv
// Port checker for the correctable error log
`timescale 1ns/10ps
`default_nettype none
module aer_log_sva
(
	// Clock, resets
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire logic hot_reset_i,
	// Bus
	input wire logic [11:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic avs_waitrequest_o,
	// Events and outputs
	input wire aer_log_pkg::corr_evt_t evt_i,
	input wire logic fep_load_i,
	input wire logic [4:0] fep_value_i,
	input wire logic err_msg_o,
	input wire aer_log_pkg::corr_evt_t err_msg_kind_o,
	input wire logic ecrc_gen_en_o,
	input wire logic ecrc_chk_en_o
);
	logic [31:0] m;
	logic [4:0] f;
	logic g;
	logic c;
	wire logic wr = avs_write_i && !avs_waitrequest_o;
	wire logic [5:0] ex = evt_i & ~{m[13], m[12], m[8], m[7], m[6], m[0]};
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rstn_i);
	// Shadow of software-written state and of the loaded first error pointer
	always_ff @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			m <= 32'h0000_2000;
			f <= 5'h00;
			g <= 1'b0;
			c <= 1'b0;
		end
		else
		begin
			if (fep_load_i)
				f <= fep_value_i;
			if (wr && avs_address_i == 12'h114)
				for (int i = 0; i < 4; i++)
					if (avs_byteenable_i[i])
						m[8*i+:8] <= avs_writedata_i[8*i+:8];
			if (wr && avs_address_i == 12'h118 && avs_byteenable_i[0])
				g <= avs_writedata_i[6];
			if (wr && avs_address_i == 12'h118 && avs_byteenable_i[1])
				c <= avs_writedata_i[8];
		end
	end
	sequence s_take;
		(avs_read_i || avs_write_i) && avs_waitrequest_o;
	endsequence
	sequence s_ans(logic [11:0] a);
		!avs_waitrequest_o && avs_read_i && avs_address_i == a;
	endsequence
	chk_req_answer:
	assert property (s_take |=> !avs_waitrequest_o) else $error("no answer");
	chk_wait_one:
	assert property ($fell(avs_waitrequest_o) |=> avs_waitrequest_o) else $error("long ack");
	chk_no_spurious:
	assert property (!avs_waitrequest_o |-> $past(avs_read_i || avs_write_i))
		else $error("ack without request");
	chk_msg_gate:
	assert property (!$past(hot_reset_i) |-> err_msg_o == (|$past(ex))
		&& (!err_msg_o || err_msg_kind_o == $past(ex))) else $error("bad message");
	chk_hot_quiet:
	assert property ($past(hot_reset_i) |-> !err_msg_o) else $error("message in hot reset");
	chk_gen_en:
	assert property (ecrc_gen_en_o == g) else $error("gen enable wrong");
	chk_chk_en:
	assert property (ecrc_chk_en_o == c) else $error("check enable wrong");
	chk_ctrl_read:
	assert property (s_ans(12'h118) |-> avs_readdata_o == {23'h0, c, 1'b1, g, 1'b1, f})
		else $error("control read wrong");
	chk_mask_read:
	assert property (s_ans(12'h114) |-> avs_readdata_o == (m & 32'h0000_31C1))
		else $error("mask read wrong");
	chk_unmapped_zero:
	assert property (!avs_waitrequest_o && avs_read_i && avs_address_i > 12'h128
		|-> avs_readdata_o == 32'h0) else $error("unmapped read nonzero");
endmodule : aer_log_sva
`default_nettype wire

// File: sim/aer_correctable_error_log_tb.sv
// Self-checking bench for the correctable error log
`timescale 1ns/10ps
`default_nettype none
module aer_correctable_error_log_tb;
	logic core_clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic hot_reset_i = 1'b0;
	logic [11:0] avs_address_i = 12'h000;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0;
	logic [3:0] avs_byteenable_i = 4'hF;
	logic [31:0] avs_readdata_o;
	logic avs_waitrequest_o;
	aer_log_pkg::corr_evt_t evt_i;
	logic evt_hdr_valid_i;
	aer_log_pkg::hdr_bytes_t evt_hdr_i;
	logic fep_load_i = 1'b0;
	logic [4:0] fep_value_i = 5'h00;
	logic err_msg_o;
	aer_log_pkg::corr_evt_t err_msg_kind_o;
	logic ecrc_gen_en_o;
	logic ecrc_chk_en_o;
	logic go = 1'b0;
	aer_log_pkg::corr_evt_t kind = '0;
	int n_errors = 0;
	int n_tests = 0;
	int seed = 56;
	int k;
	int pos[6] = '{0, 6, 7, 8, 12, 13};
	logic [31:0] st = 32'h0;
	logic [31:0] mk = 32'h0000_2000;
	logic [31:0] r;
	logic [31:0] d;
	logic [127:0] hl = 128'h0;
	aer_correctable_error_log aer_correctable_error_log_inst (.*);
	link_err_src link_err_src_inst (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .go_i(go),
		.kind_i(kind), .evt_o(evt_i), .hdr_valid_o(evt_hdr_valid_i), .hdr_o(evt_hdr_i));
	initial
		forever #25 core_clk_i = ~core_clk_i;
	task automatic wrap_up;
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : wrap_up
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
		int i;
		i = 0;
		avs_address_i <= a;
		avs_writedata_i <= wd;
		avs_write_i <= w;
		avs_read_i <= !w;
		do
		begin
			@(posedge core_clk_i);
			i++;
		end
		while (avs_waitrequest_o !== 1'b0 && i < 20);
		if (i >= 20)
		begin
			n_errors++;
			wrap_up();
		end
		r = avs_readdata_o;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
		@(posedge core_clk_i);
	endtask : bus
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(r, e);
	endtask : rd
	// Big-endian bytes within each logged dword
	function automatic logic [127:0] pack(input aer_log_pkg::hdr_bytes_t h);
		logic [127:0] v;
		for (int n = 0; n < 16; n++)
			v[32*(n/4)+8*(3-n%4)+:8] = h[n];
		return v;
	endfunction : pack
	task automatic fire(input int b);
		kind <= 6'(1 << b);
		go <= 1'b1;
		@(posedge core_clk_i);
		go <= 1'b0;
		@(posedge core_clk_i);
		st[pos[b]] = 1'b1;
		if (!mk[pos[b]])
			hl = pack(evt_hdr_i);
	endtask : fire
	task automatic log_chk;
		rd(12'h110, st);
		for (int n = 0; n < 4; n++)
			rd(12'h11C + 12'(4 * n), hl[32*n+:32]);
	endtask : log_chk
	initial
	begin
		repeat (4) @(posedge core_clk_i);
		rstn_i <= 1'b1;
		@(posedge core_clk_i);
		rd(12'h114, 32'h0000_2000);
		rd(12'h118, 32'h0000_00A0);
		rd(12'h12C, 32'h0);
		log_chk();
		$display("reset values done");
		bus(1'b1, 12'h118, 32'hFFFF_FFFF);
		rd(12'h118, 32'h0000_01E0);
		chk({30'h0, ecrc_gen_en_o, ecrc_chk_en_o}, 32'h3);
		fep_value_i <= 5'h13;
		fep_load_i <= 1'b1;
		@(posedge core_clk_i);
		fep_load_i <= 1'b0;
		bus(1'b1, 12'h118, 32'h0);
		rd(12'h118, 32'h0000_00B3);
		bus(1'b1, 12'h11C, 32'hFFFF_FFFF);
		$display("control done");
		for (int b = 0; b < 6; b++)
			fire(b);
		log_chk();
		rd(12'h110, 32'h0000_31C1);
		for (int j = 0; j < 30; j++)
		begin
			if (j % 5 == 4)
			begin
				d = $random(seed);
				bus(1'b1, 12'h114, d);
				mk = d & 32'h0000_31C1;
				rd(12'h114, mk);
			end
			k = ($random(seed) % 6 + 6) % 6;
			fire(k);
			log_chk();
			if (j % 3 == 2)
			begin
				d = $random(seed);
				bus(1'b1, 12'h110, d);
				st = st & ~d;
				rd(12'h110, st);
			end
		end
		$display("random events done");
		hot_reset_i <= 1'b1;
		fire(0);
		hot_reset_i <= 1'b0;
		log_chk();
		rd(12'h114, mk);
		rd(12'h118, 32'h0000_00B3);
		$display("hot reset done");
		wrap_up();
	end
endmodule : aer_correctable_error_log_tb
bind aer_correctable_error_log aer_log_sva aer_log_sva_inst (.*);
`default_nettype wire
